// *** sbtc_assertions.sv ***
// port level checker for the sixteen bit timer counter
`timescale 1ns/1ns
module sbtc_assertions
   import sbtc_pkg::*;
(
   input wire logic        CORE_CLK,
   input wire logic        RESET,
   input wire logic [2:0]  ADDR,
   input wire logic [7:0]  WDATA,
   input wire logic        WR,
   input wire logic        RD,
   input wire logic [7:0]  RDATA,
   input wire logic        LOWPOWER_OSC_ENABLE,
   input wire logic [1:0]  OSC_PIN_IN,
   input wire logic [1:0]  PORT_DIRECTION_BITS,
   input wire logic [1:0]  OSC_PIN_READ,
   input wire logic [1:0]  OSC_PIN_OE,
   input wire logic        SPECIAL_EVENT,
   input wire logic [15:0] CAPTURE_TIMEBASE,
   input wire logic        CAPTURE_USES_THIS,
   input wire logic        OVERFLOW_IRQ
);
   import sbtc_pkg::*;
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (RESET);
   // ====
   // bus, pins, timebase and interrupt
   rdata_idle_a: assert property (!$past(RD) |-> RDATA == 8'h00)
      else $error("read data not idle");
   osc_off_a: assert property ($past(LOWPOWER_OSC_ENABLE) |-> OSC_PIN_READ == 2'h0
      && OSC_PIN_OE == 2'h0) else $error("oscillator pins not shut off");
   osc_pass_a: assert property (!$past(RESET) && !$past(LOWPOWER_OSC_ENABLE) |->
      OSC_PIN_OE == ~$past(PORT_DIRECTION_BITS) && OSC_PIN_READ == $past(OSC_PIN_IN))
      else $error("oscillator pins not passed through");
   sel_copy_a: assert property (WR && ADDR == ADDR_CONTROL |=>
      CAPTURE_USES_THIS == $past(WDATA[BIT_TIMEBASE])) else $error("timebase select lost");
   sel_hold_a: assert property (!(WR && ADDR == ADDR_CONTROL) |=> $stable(CAPTURE_USES_THIS))
      else $error("timebase select moved");
   se_zero_a: assert property (CAPTURE_USES_THIS && SPECIAL_EVENT && !WR |=>
      CAPTURE_TIMEBASE == COUNT_RESET) else $error("special event did not clear");
   write_wins_a: assert property (CAPTURE_USES_THIS && SPECIAL_EVENT && WR
      && ADDR == ADDR_COUNT_LOW |=> CAPTURE_TIMEBASE[7:0] == $past(WDATA))
      else $error("count write lost to special event");
   irq_off_a: assert property (WR && ADDR == ADDR_ENABLE && !WDATA[BIT_OVERFLOW]
      |-> ##[1:2] !OVERFLOW_IRQ) else $error("masked request still high");
endmodule : sbtc_assertions

bind sbtc_top sbtc_assertions i_sbtc_assertions (.CORE_CLK, .RESET, .ADDR, .WDATA, .WR, .RD,
   .RDATA, .LOWPOWER_OSC_ENABLE, .OSC_PIN_IN, .PORT_DIRECTION_BITS, .OSC_PIN_READ,
   .OSC_PIN_OE, .SPECIAL_EVENT, .CAPTURE_TIMEBASE, .CAPTURE_USES_THIS, .OVERFLOW_IRQ);

// *** sbtc_core_model.sv ***
// processor core model issuing byte register accesses
`timescale 1ns/1ns
module sbtc_core_model (
   input  wire logic       clk,
   output      logic [2:0] addr,
   output      logic [7:0] wdata,
   output      logic       wr,
   output      logic       rd,
   input  wire logic [7:0] rdata
);
   initial begin
      addr = 3'h0;
      wdata = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
   end
   // ====
   // one cycle strobes, changed just after the rising edge
   task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg
   // data stands only in the cycle after the strobe, taken mid cycle
   task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      d = rdata;
   endtask : rd_reg
endmodule : sbtc_core_model

// *** sbtc_edge.sv ***
// rising edge detector for the external count input, optional synchroniser
`timescale 1ns/1ns
module sbtc_edge
   import sbtc_pkg::*;
(
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic src,
   input  wire logic bypass,
   input  wire logic rearm,
   output      logic rise
);

   sbtc_edge_s s_q;
   sbtc_edge_s s_d;
   logic       level;

   // ==========================================================
   // next state
   always_comb begin
      s_d      = s_q;
      s_d.meta = src;
      s_d.sync = s_q.meta;
      // the synchroniser costs two cycles of latency; bypass trades that for metastability risk
      level    = bypass ? src : s_q.sync;
      s_d.prev = level;
      s_d.rise = 1'b0;
      if (rearm) begin
         s_d.state = EDGE_WAIT_FALL;
      end else begin
         unique case (s_q.state)
            EDGE_WAIT_FALL: begin
               if (s_q.prev && !level) begin
                  s_d.state = EDGE_ARMED;
               end
            end
            EDGE_ARMED: begin
               s_d.rise = !s_q.prev && level;
            end
            default: s_d.state = EDGE_WAIT_FALL;
         endcase
      end
   end

   // ==========================================================
   // registers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_q <= '{meta: 1'b0, sync: 1'b0, prev: 1'b0, state: EDGE_WAIT_FALL, rise: 1'b0};
      end else begin
         s_q <= s_d;
      end
   end

   assign rise = s_q.rise;

endmodule : sbtc_edge

// *** sbtc_pkg.sv ***
// constants and state types shared by the sixteen bit timer counter
package sbtc_pkg;

   // ==========================================================
   // register map (byte registers, 3 bit address)
   localparam logic [2:0] ADDR_CONTROL   = 3'h0;
   localparam logic [2:0] ADDR_COUNT_LOW = 3'h1;
   localparam logic [2:0] ADDR_COUNT_HI  = 3'h2;
   localparam logic [2:0] ADDR_FLAG      = 3'h3;
   localparam logic [2:0] ADDR_ENABLE    = 3'h4;

   // ==========================================================
   // control register fields
   localparam int BIT_BUFFERED   = 7;
   localparam int BIT_PRESC_HI   = 5;
   localparam int BIT_PRESC_LO   = 4;
   localparam int BIT_TIMEBASE   = 3;
   localparam int BIT_SYNC_DIS   = 2;
   localparam int BIT_CLK_SOURCE = 1;
   localparam int BIT_TIMER_ON   = 0;
   localparam logic [7:0] CONTROL_WMASK = 8'hbf;
   localparam logic [7:0] CONTROL_RESET = 8'h00;

   // flag and enable registers: overflow bit position
   localparam int BIT_OVERFLOW = 1;

   // ==========================================================
   // timing: instruction cycle is the core clock divided by four
   localparam int          CORE_CLK_HZ  = 10_000_000;
   localparam int          INSTR_DIV    = 4;
   localparam logic [1:0]  INSTR_LAST   = 2'(INSTR_DIV - 1);
   localparam logic [15:0] COUNT_MAX    = 16'hffff;
   localparam logic [15:0] COUNT_RESET  = 16'h0000;

   // ==========================================================
   // prescale select codes
   localparam logic [1:0] PRESC_1 = 2'h0;
   localparam logic [1:0] PRESC_2 = 2'h1;
   localparam logic [1:0] PRESC_4 = 2'h2;
   localparam logic [1:0] PRESC_8 = 2'h3;

   // ==========================================================
   // edge detector arming states
   typedef enum logic [1:0] {
      EDGE_WAIT_FALL = 2'b01,
      EDGE_ARMED     = 2'b10
   } sbtc_edge_e;

   typedef struct packed {
      logic       meta;
      logic       sync;
      logic       prev;
      sbtc_edge_e state;
      logic       rise;
   } sbtc_edge_s;

   typedef struct packed {
      logic [7:0]  control;
      logic [15:0] count;
      logic [7:0]  high_buf;
      logic [2:0]  presc;
      logic [1:0]  instr_div;
      logic        overflow_flag;
      logic        overflow_int_enable;
      logic        clk_src_prev;
      logic [7:0]  rdata;
      logic        irq;
      logic [15:0] timebase;
      logic        timebase_sel;
      logic [1:0]  osc_pin_read;
      logic [1:0]  osc_pin_oe;
   } sbtc_state_s;

endpackage : sbtc_pkg

// *** sbtc_tb_top.sv ***
// self checking testbench for the sixteen bit timer counter
`timescale 1ns/1ns
module sbtc_tb_top;
   import sbtc_pkg::*;
   logic clk = 1'b0, rst = 1'b1, pin = 1'b0, osc = 1'b0, osc_en = 1'b0, se = 1'b0;
   logic [2:0] addr;
   logic [7:0] wdata, rdata;
   logic wr, rd, uses, irq;
   logic [1:0] pread, poe;
   logic [15:0] tb;
   int fails = 0, compares = 0;
   always #50 clk = ~clk;
   sbtc_core_model i_sbtc_core_model (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd), .rdata(rdata));
   sbtc_top i_sbtc_top (.CORE_CLK(clk), .RESET(rst), .ADDR(addr), .WDATA(wdata), .WR(wr),
      .RD(rd), .RDATA(rdata), .EXTERNAL_COUNT_PIN(pin), .LOWPOWER_OSC_CLK(osc),
      .LOWPOWER_OSC_ENABLE(osc_en), .OSC_PIN_IN({1'b1, pin}), .PORT_DIRECTION_BITS({osc, 1'b1}),
      .OSC_PIN_READ(pread), .OSC_PIN_OE(poe), .SPECIAL_EVENT(se),
      .COMPANION_COUNT(16'hc3c3), .CAPTURE_TIMEBASE(tb), .CAPTURE_USES_THIS(uses),
      .OVERFLOW_IRQ(irq));
   // ====
   // helpers
   task automatic check(input string n, input logic [15:0] e, input logic [15:0] g);
      compares++;
      if (g !== e) begin
         fails++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask : check
   task automatic w(input logic [2:0] a, input logic [7:0] d);
      i_sbtc_core_model.wr_reg(a, d);
   endtask : w
   task automatic rc(input string n, input logic [2:0] a, input logic [15:0] e);
      logic [7:0] d;
      i_sbtc_core_model.rd_reg(a, d);
      check(n, e, {8'h00, d});
   endtask : rc
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : cyc
   // cycles between two timebase steps, the first partial step skipped
   task automatic gap(output int n);
      logic [15:0] v;
      n = 0;
      @(negedge clk) v = tb;
      for (int i = 0; i < 80 && tb === v; i++) @(negedge clk);
      v = tb;
      for (int i = 1; i < 80 && n == 0; i++) begin
         @(negedge clk);
         if (tb !== v) n = i;
      end
   endtask : gap
   // ====
   // scenarios
   task automatic t_regs();
      for (int a = 0; a < 8; a++) rc("reset", 3'(a), 16'h0000);
      w(ADDR_CONTROL, 8'hff);
      @(negedge clk) check("uses", 16'h0001, uses);
      rc("ctl", ADDR_CONTROL, {8'h00, CONTROL_WMASK});
      w(ADDR_CONTROL, 8'h00);
      @(negedge clk) check("uses off", 16'h0000, uses);
      w(3'h5, 8'hff);
      rc("unmapped", 3'h5, 16'h0000);
      check("companion", 16'hc3c3, tb);
      check("pins", 16'h000a, {pread, poe});
   endtask : t_regs
   task automatic t_rate();
      int n;
      for (int p = 0; p < 4; p++) begin
         w(ADDR_CONTROL, 8'h09 | 8'(p << 4));
         gap(n);
         check("step", 16'(INSTR_DIV << p), 16'(n));
      end
      w(ADDR_CONTROL, 8'h08);
      gap(n);
      check("stopped", 16'h0000, 16'(n));
   endtask : t_rate
   task automatic t_ext();
      for (int k = 0; k < 3; k++) begin
         w(ADDR_CONTROL, 8'h08);
         w(ADDR_COUNT_LOW, 8'h00);
         pin <= 1'b0;
         osc_en <= (k == 2);
         w(ADDR_CONTROL, (k == 1) ? 8'h0f : 8'h0b);
         // first rise comes before any fall and must not count
         repeat (5) begin
            cyc(6);
            if (k == 2) osc <= ~osc;
            else pin <= ~pin;
         end
         // bypass sees the last rise two cycles sooner than the synchroniser
         cyc(2);
         @(negedge clk) check("latency", (k == 1) ? 16'h0002 : 16'h0001, tb);
         cyc(4);
         @(negedge clk) check("edges", 16'h0002, tb);
      end
      check("osc pins", 16'h0000, {pread, poe});
      osc_en <= 1'b0;
   endtask : t_ext
   task automatic t_buf();
      w(ADDR_CONTROL, 8'h88);
      w(ADDR_COUNT_HI, 8'hab);
      rc("buffer", ADDR_COUNT_HI, 16'h00ab);
      w(ADDR_COUNT_LOW, 8'hcd);
      @(negedge clk) check("pair", 16'habcd, tb);
      w(ADDR_COUNT_HI, 8'h11);
      @(negedge clk) check("live hi", 16'habcd, tb);
      rc("lo", ADDR_COUNT_LOW, 16'h00cd);
      rc("hi", ADDR_COUNT_HI, 16'h00ab);
      w(ADDR_CONTROL, 8'h08);
      w(ADDR_COUNT_HI, 8'h5e);
      @(negedge clk) check("direct", 16'h5ecd, tb);
   endtask : t_buf
   task automatic t_ovf();
      w(ADDR_COUNT_HI, 8'hff);
      w(ADDR_COUNT_LOW, 8'hfe);
      w(ADDR_CONTROL, 8'h09);
      cyc(20);
      w(ADDR_CONTROL, 8'h08);
      rc("flag", ADDR_FLAG, 16'h0002);
      rc("wrapped", ADDR_COUNT_HI, 16'h0000);
      check("masked", 16'h0000, irq);
      w(ADDR_ENABLE, 8'h02);
      cyc(2);
      @(negedge clk) check("irq", 16'h0001, irq);
      w(ADDR_ENABLE, 8'h00);
      cyc(2);
      @(negedge clk) check("irq off", 16'h0000, irq);
   endtask : t_ovf
   task automatic t_se();
      // timer mode only, the reset is not trusted when counting asynchronously
      w(ADDR_COUNT_LOW, 8'h34);
      se <= 1'b1;
      @(posedge clk) se <= 1'b0;
      @(negedge clk) check("cleared", 16'h0000, tb);
      fork
         w(ADDR_COUNT_LOW, 8'h55);
         begin
            @(posedge clk) se <= 1'b1;
            @(posedge clk) se <= 1'b0;
         end
      join
      rc("write wins", ADDR_COUNT_LOW, 16'h0055);
      w(ADDR_CONTROL, 8'h00);
      w(ADDR_COUNT_LOW, 8'h77);
      se <= 1'b1;
      @(posedge clk) se <= 1'b0;
      rc("not base", ADDR_COUNT_LOW, 16'h0077);
   endtask : t_se
   task automatic t_reset();
      // flag is still set from the overflow test, so the reset has work to do
      w(ADDR_ENABLE, 8'h02);
      w(ADDR_CONTROL, 8'h88);
      rst <= 1'b1;
      cyc(2);
      rst <= 1'b0;
      cyc(1);
      check("irq reset", 16'h0000, irq);
      rc("flag reset", ADDR_FLAG, 16'h0000);
      rc("en reset", ADDR_ENABLE, 16'h0000);
      rc("ctl reset", ADDR_CONTROL, 16'h0000);
      rc("low reset", ADDR_COUNT_LOW, 16'h0000);
   endtask : t_reset
   // ====
   // run control
   task automatic tally_and_finish();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : tally_and_finish
   initial begin
      cyc(20);
      rst <= 1'b0;
      cyc(1);
      t_regs();
      $display("test regs done");
      t_rate();
      $display("test rate done");
      t_ext();
      $display("test external done");
      t_buf();
      $display("test buffered done");
      t_ovf();
      $display("test overflow done");
      t_se();
      $display("test special event done");
      t_reset();
      $display("test reset done");
      tally_and_finish();
   end
   // tests need well under a millisecond of simulated time
   initial begin
      #2_000_000;
      fails++;
      tally_and_finish();
   end
endmodule : sbtc_tb_top

// *** sbtc_top.sv ***
// sixteen bit timer counter with prescaler, buffered access and overflow flag
//
// Operation
// - buffered bit set makes count access one 16-bit operation; clear gives two bytes.
// - two-bit prescale field divides counting clock by 1, 2, 4 or 8.
// - timebase select bit 1 gives this count to capture unit, else companion's.
// - external source: sync-disable bit 1 skips synchroniser; ignored for internal clock.
// - external source counts rising edges, starting after first falling edge seen.
// - timer-on bit enables counting when set, stops timer when clear.
// - internal source increments once every instruction cycle, core clock divided by four.
// - while low-power oscillator runs, its pins' logic is off and read zero.
// - buffered mode low-byte read copies live high byte into buffer.
// - buffered mode low-byte write loads high byte from buffer too.
// - buffered mode high-byte address reaches only the buffer.
// - low-byte write clears prescaler; high-byte write does not.
// - count wraps from maximum to zero and sets overflow flag.
// - interrupt request only while overflow interrupt enable is set.
// - special event trigger while this timer is timebase resets count to zero.
// - software count write in same cycle beats special event reset.
`timescale 1ns/1ns
module sbtc_top
   import sbtc_pkg::*;
(
   input  wire logic                  CORE_CLK,
   input  wire logic                  RESET,
   input  wire logic [2:0]            ADDR,
   input  wire logic [7:0]            WDATA,
   input  wire logic                  WR,
   input  wire logic                  RD,
   output      logic [7:0]            RDATA,
   input  wire logic                  EXTERNAL_COUNT_PIN,
   input  wire logic                  LOWPOWER_OSC_CLK,
   input  wire logic                  LOWPOWER_OSC_ENABLE,
   input  wire logic [1:0]            OSC_PIN_IN,
   input  wire logic [1:0]            PORT_DIRECTION_BITS,
   output      logic [1:0]            OSC_PIN_READ,
   output      logic [1:0]            OSC_PIN_OE,
   input  wire logic                  SPECIAL_EVENT,
   input  wire logic [15:0]           COMPANION_COUNT,
   output      logic [15:0]           CAPTURE_TIMEBASE,
   output      logic                  CAPTURE_USES_THIS,
   output      logic                  OVERFLOW_IRQ
);
   import sbtc_pkg::*;

   // ==========================================================
   // helpers
   function automatic logic [2:0] presc_last(input logic [1:0] sel);
      unique case (sel)
         PRESC_1: presc_last = 3'h0;
         PRESC_2: presc_last = 3'h1;
         PRESC_4: presc_last = 3'h3;
         PRESC_8: presc_last = 3'h7;
      endcase
   endfunction : presc_last

   function automatic logic hit(input logic strobe, input logic [2:0] a, input logic [2:0] b);
      hit = strobe && (a == b);
   endfunction : hit

   sbtc_state_s s_q;
   sbtc_state_s s_d;
   logic        ext_src;
   logic        ext_rise;
   logic        clk_src_rearm;

   // ==========================================================
   // external count source and its edge detector
   // the oscillator replaces the pin only once software has enabled it
   assign ext_src       = LOWPOWER_OSC_ENABLE ? LOWPOWER_OSC_CLK : EXTERNAL_COUNT_PIN;
   assign clk_src_rearm = s_q.control[BIT_CLK_SOURCE] && !s_q.clk_src_prev;

   sbtc_edge u_edge (
      .clk    (CORE_CLK),
      .rst    (RESET),
      .src    (ext_src),
      .bypass (s_q.control[BIT_SYNC_DIS]),
      .rearm  (clk_src_rearm),
      .rise   (ext_rise)
   );

   // ==========================================================
   // next state
   logic        wr_ctrl;
   logic        wr_low;
   logic        wr_high;
   logic        wr_flag;
   logic        wr_en;
   logic        rd_low;
   logic        rd_high;
   logic        rd_ctrl;
   logic        rd_flag;
   logic        rd_en;
   logic        buffered;
   logic        src_tick;
   logic        cnt_tick;
   logic        wrap;
   logic [15:0] count_inc;

   always_comb begin
      s_d       = s_q;
      wr_ctrl   = hit(WR, ADDR, ADDR_CONTROL);
      wr_low    = hit(WR, ADDR, ADDR_COUNT_LOW);
      wr_high   = hit(WR, ADDR, ADDR_COUNT_HI);
      wr_flag   = hit(WR, ADDR, ADDR_FLAG);
      wr_en     = hit(WR, ADDR, ADDR_ENABLE);
      rd_low    = hit(RD, ADDR, ADDR_COUNT_LOW);
      rd_high   = hit(RD, ADDR, ADDR_COUNT_HI);
      rd_ctrl   = hit(RD, ADDR, ADDR_CONTROL);
      rd_flag   = hit(RD, ADDR, ADDR_FLAG);
      rd_en     = hit(RD, ADDR, ADDR_ENABLE);
      buffered  = s_q.control[BIT_BUFFERED];
      src_tick  = 1'b0;
      cnt_tick  = 1'b0;
      wrap      = 1'b0;
      count_inc = s_q.count + 16'h0001;

      s_d.clk_src_prev = s_q.control[BIT_CLK_SOURCE];

      // ---- instruction cycle divider, free running
      if (s_q.instr_div == INSTR_LAST) begin
         s_d.instr_div = 2'h0;
      end else begin
         s_d.instr_div = s_q.instr_div + 2'h1;
      end

      // ---- pick the counting clock
      if (s_q.control[BIT_CLK_SOURCE]) begin
         src_tick = ext_rise;
      end else begin
         src_tick = (s_q.instr_div == INSTR_LAST);
      end

      // ---- prescaler, counting only while the timer is on
      if (s_q.control[BIT_TIMER_ON] && src_tick) begin
         if (s_q.presc >= presc_last(s_q.control[BIT_PRESC_HI:BIT_PRESC_LO])) begin
            s_d.presc = 3'h0;
            cnt_tick  = 1'b1;
         end else begin
            s_d.presc = s_q.presc + 3'h1;
         end
      end

      // ---- count: increment, then special event, then software write wins
      if (cnt_tick) begin
         s_d.count = count_inc;
         wrap      = (s_q.count == COUNT_MAX);
      end
      if (SPECIAL_EVENT && s_q.control[BIT_TIMEBASE]) begin
         // in asynchronous counter mode the reset may race the edge; software avoids that
         s_d.count = COUNT_RESET;
         wrap      = 1'b0;
      end
      if (wr_low) begin
         s_d.presc = 3'h0;
         if (buffered) begin
            s_d.count = {s_q.high_buf, WDATA};
         end else begin
            s_d.count[7:0] = WDATA;
         end
      end
      if (wr_high) begin
         if (buffered) begin
            s_d.high_buf = WDATA;
         end else begin
            s_d.count[15:8] = WDATA;
         end
      end

      // ---- control and enable registers
      if (wr_ctrl) begin
         s_d.control = WDATA & CONTROL_WMASK;
      end
      if (wr_en) begin
         s_d.overflow_int_enable = WDATA[BIT_OVERFLOW];
      end

      // ---- overflow flag: a wrap in the clearing cycle still sets it
      if (wr_flag) begin
         s_d.overflow_flag = WDATA[BIT_OVERFLOW];
      end
      if (wrap) begin
         s_d.overflow_flag = 1'b1;
      end
      s_d.irq = s_d.overflow_flag && s_d.overflow_int_enable;

      // ---- read data, valid only in the cycle after the strobe
      s_d.rdata = 8'h00;
      if (rd_ctrl) begin
         s_d.rdata = s_q.control;
      end
      if (rd_low) begin
         s_d.rdata = s_q.count[7:0];
         if (buffered) begin
            s_d.high_buf = s_q.count[15:8];
         end
      end
      if (rd_high) begin
         s_d.rdata = buffered ? s_q.high_buf : s_q.count[15:8];
      end
      if (rd_flag) begin
         s_d.rdata[BIT_OVERFLOW] = s_q.overflow_flag;
      end
      if (rd_en) begin
         s_d.rdata[BIT_OVERFLOW] = s_q.overflow_int_enable;
      end

      // ---- capture time base choice
      s_d.timebase_sel = s_d.control[BIT_TIMEBASE];
      s_d.timebase     = s_d.control[BIT_TIMEBASE] ? s_d.count : COMPANION_COUNT;

      // ---- oscillator pins: digital path off while the oscillator runs
      if (LOWPOWER_OSC_ENABLE) begin
         s_d.osc_pin_read = 2'h0;
         s_d.osc_pin_oe   = 2'h0;
      end else begin
         s_d.osc_pin_read = OSC_PIN_IN;
         s_d.osc_pin_oe   = ~PORT_DIRECTION_BITS;
      end
   end

   // ==========================================================
   // registers
   always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         s_q <= '{control:             CONTROL_RESET,
                  count:               COUNT_RESET,
                  high_buf:            8'h00,
                  presc:               3'h0,
                  instr_div:           2'h0,
                  overflow_flag:       1'b0,
                  overflow_int_enable: 1'b0,
                  clk_src_prev:        1'b0,
                  rdata:               8'h00,
                  irq:                 1'b0,
                  timebase:            16'h0000,
                  timebase_sel:        1'b0,
                  osc_pin_read:        2'h0,
                  osc_pin_oe:          2'h0};
      end else begin
         s_q <= s_d;
      end
   end

   // ==========================================================
   // outputs, all straight from the state register
   assign RDATA             = s_q.rdata;
   assign OVERFLOW_IRQ      = s_q.irq;
   assign CAPTURE_TIMEBASE  = s_q.timebase;
   assign CAPTURE_USES_THIS = s_q.timebase_sel;
   assign OSC_PIN_READ      = s_q.osc_pin_read;
   assign OSC_PIN_OE        = s_q.osc_pin_oe;

endmodule : sbtc_top
